// File: logic/frs_sequencer.sv
// Per-node error recovery sequencer
`timescale 1ns/100ps
`include "frs_defs.svh"

module frs_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Initialization
    input wire logic init,
    input wire logic [7:0] node_addr_in,
    output logic [7:0] node_addr,
    // Configuration
    input wire logic [20:0] wait_time_us,
    input wire logic node_is_bus_interface,
    input wire logic [3:0] attached_procs,
    // Error report line
    input wire logic err_valid,
    input wire frs_pkg::frs_rpt_t err_rpt,
    input wire logic det_valid,
    input wire frs_pkg::frs_rpt_t det_rpt,
    output logic bcast_valid,
    output frs_pkg::frs_rpt_t bcast_rpt,
    // Local access tracking
    input wire logic acc_start,
    input wire logic [2:0] acc_start_tag,
    input wire logic acc_done,
    input wire logic [2:0] acc_done_tag,
    output logic quiescent,
    output logic retry_valid,
    output logic [2:0] retry_tag,
    // Reconfiguration
    output logic isolate_valid,
    output frs_pkg::frs_rpt_t isolate_rpt,
    output logic spare_enable,
    output logic reconf_msg_valid,
    output logic [3:0] reconf_msg_dest,
    // Log
    output logic log_valid,
    output frs_pkg::frs_rpt_t log_rpt,
    output logic perm_flag
);
    import frs_pkg::*;

    localparam int US_CYC = (`FRS_US_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS;

    frs_state_t state;
    logic [7:0] us_div;
    logic us_tick;
    logic [20:0] wait_cnt;
    logic [7:0] outst, retry_mask;
    logic [3:0] watch;
    logic new_err, same_err, retry_end, wait_end;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [20:0] clamp_wait(input logic [20:0] v);
        return (v < `FRS_WAIT_MIN_US) ? `FRS_WAIT_MIN_US : ((v > `FRS_WAIT_MAX_US) ? `FRS_WAIT_MAX_US : v);
    endfunction

    function automatic logic [2:0] low_tag(input logic [7:0] m);
        logic [2:0] t;
        t = 3'h0;
        for (int i = `FRS_TAGS - 1; i >= 0; i--) begin
            if (m[i])
                t = 3'(i);
        end
        return t;
    endfunction

    assign new_err = err_valid && !init;
    assign same_err = new_err && log_valid && (err_rpt == log_rpt);
    assign retry_end = (retry_mask == 8'h00) && (watch == 4'h0);
    assign wait_end = (wait_cnt == 21'h0);

    // ----------------------------------------
    // Microsecond tick
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            us_div <= 8'h00;
            us_tick <= 1'b0;
        end else if (init || state == FRS_IDLE) begin
            us_div <= 8'h00;
            us_tick <= 1'b0;
        end else if (us_div == 8'(US_CYC - 1)) begin
            us_div <= 8'h00;
            us_tick <= 1'b1;
        end else begin
            us_div <= us_div + 8'h01;
            us_tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FRS_IDLE;
            wait_cnt <= 21'h0;
            perm_flag <= 1'b0;
        end else if (init) begin
            state <= FRS_IDLE;
            wait_cnt <= 21'h0;
            perm_flag <= 1'b0;
        end else begin
            case (state)
                FRS_IDLE: begin
                    if (new_err) begin
                        state <= FRS_WAIT1;
                        wait_cnt <= clamp_wait(wait_time_us);
                        perm_flag <= 1'b0;
                    end
                end
                FRS_WAIT1, FRS_WAIT2: begin
                    if (wait_end) begin
                        state <= (state == FRS_WAIT1) ? FRS_RETRY1 : FRS_RETRY2;
                    end else if (us_tick) begin
                        wait_cnt <= wait_cnt - 21'h1;
                    end
                end
                FRS_RETRY1: begin
                    if (same_err) begin
                        state <= FRS_WAIT2;
                        perm_flag <= 1'b1;
                        wait_cnt <= clamp_wait(wait_time_us);
                    end else if (new_err) begin
                        state <= FRS_WAIT1;
                        wait_cnt <= clamp_wait(wait_time_us);
                    end else if (retry_end) begin
                        state <= FRS_IDLE;
                    end
                end
                FRS_RETRY2: begin
                    if (retry_end) begin
                        state <= FRS_IDLE;
                    end
                end
                default: begin
                    state <= FRS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Quiescent output
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiescent <= 1'b0;
        end else if (init) begin
            quiescent <= 1'b0;
        end else if (new_err && state != FRS_RETRY2) begin
            quiescent <= 1'b1;
        end else if (retry_end && (state == FRS_RETRY1 || state == FRS_RETRY2)) begin
            quiescent <= 1'b0;
        end
    end

    // ----------------------------------------
    // Outstanding accesses and retry replay
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outst <= 8'h00;
        end else if (init) begin
            outst <= 8'h00;
        end else begin
            for (int i = 0; i < `FRS_TAGS; i++) begin
                if (acc_start && !quiescent && acc_start_tag == 3'(i))
                    outst[i] <= 1'b1;
                else if (acc_done && acc_done_tag == 3'(i))
                    outst[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            retry_mask <= 8'h00;
            watch <= 4'h0;
            retry_valid <= 1'b0;
            retry_tag <= 3'h0;
        end else if (init) begin
            retry_mask <= 8'h00;
            watch <= 4'h0;
            retry_valid <= 1'b0;
            retry_tag <= 3'h0;
        end else if ((state == FRS_WAIT1 || state == FRS_WAIT2) && wait_end) begin
            retry_mask <= outst;
            watch <= `FRS_RETRY_WATCH;
            retry_valid <= 1'b0;
        end else if (retry_mask != 8'h00) begin
            retry_valid <= 1'b1;
            retry_tag <= low_tag(retry_mask);
            retry_mask[low_tag(retry_mask)] <= 1'b0;
        end else begin
            retry_valid <= 1'b0;
            if (watch != 4'h0)
                watch <= watch - 4'h1;
        end
    end

    // ----------------------------------------
    // Error log and broadcast
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            log_valid <= 1'b0;
            log_rpt <= '0;
        end else if (init) begin
            log_valid <= 1'b0;
            log_rpt <= '0;
        end else if (new_err) begin
            log_valid <= 1'b1;
            log_rpt <= err_rpt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bcast_valid <= 1'b0;
            bcast_rpt <= '0;
        end else begin
            bcast_valid <= det_valid && !init;
            if (det_valid)
                bcast_rpt <= det_rpt;
        end
    end

    // ----------------------------------------
    // Reconfiguration and notification
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isolate_valid <= 1'b0;
            isolate_rpt <= '0;
            spare_enable <= 1'b0;
        end else if (init) begin
            isolate_valid <= 1'b0;
            isolate_rpt <= '0;
            spare_enable <= 1'b0;
        end else begin
            isolate_valid <= 1'b0;
            if (state == FRS_RETRY1 && same_err) begin
                isolate_valid <= 1'b1;
                isolate_rpt <= err_rpt;
                spare_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reconf_msg_valid <= 1'b0;
            reconf_msg_dest <= 4'h0;
        end else begin
            reconf_msg_valid <= 1'b0;
            if (!init && state == FRS_RETRY2 && retry_end && node_is_bus_interface) begin
                reconf_msg_valid <= 1'b1;
                reconf_msg_dest <= attached_procs;
            end
        end
    end

    // ----------------------------------------
    // Node address
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            node_addr <= 8'h00;
        end else if (init) begin
            node_addr <= node_addr_in;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_START: assert property (state == FRS_IDLE && new_err |=> state == FRS_WAIT1 && quiescent)
        else $error("recovery did not start");
    AST_QUIET: assert property ((state == FRS_WAIT1 || state == FRS_WAIT2) |-> quiescent)
        else $error("not quiescent in wait");
    AST_LOAD: assert property (state == FRS_IDLE && new_err |=> wait_cnt >= `FRS_WAIT_MIN_US)
        else $error("wait below minimum");
    AST_COUNT: assert property (state == FRS_WAIT1 && !wait_end && !init && us_tick
        |=> wait_cnt == $past(wait_cnt) - 21'h1)
        else $error("wait counter did not step");
    AST_RETRY: assert property (state == FRS_WAIT1 && wait_end && !init |=> state == FRS_RETRY1
        && retry_mask == $past(outst))
        else $error("retry not started");
    AST_PERM: assert property (state == FRS_RETRY1 && same_err && !init
        |=> perm_flag && state == FRS_WAIT2 && isolate_valid && isolate_rpt == log_rpt)
        else $error("recurrence not permanent");
    AST_ISO_WAIT: assert property (isolate_valid |-> state == FRS_WAIT2 && spare_enable)
        else $error("isolation outside second wait");
    AST_MSG: assert property (reconf_msg_valid |-> perm_flag && $past(node_is_bus_interface)
        && reconf_msg_dest == $past(attached_procs))
        else $error("bad processor message");
    AST_TRANS: assert property (state == FRS_RETRY1 && retry_end && !new_err && !init
        |=> state == FRS_IDLE && !perm_flag && !reconf_msg_valid && $stable(spare_enable))
        else $error("transient reconfigured");
    AST_BCAST: assert property (det_valid && !init |=> bcast_valid && bcast_rpt == $past(det_rpt))
        else $error("detection not broadcast");
    AST_LOG: assert property (new_err |=> log_valid && log_rpt == $past(err_rpt))
        else $error("log not updated");
    AST_INIT: assert property (init |=> state == FRS_IDLE && node_addr == $past(node_addr_in))
        else $error("init state wrong");

    COV_TRANSIENT: cover property (state == FRS_RETRY1 ##1 state == FRS_IDLE);
    COV_PERMANENT: cover property (state == FRS_RETRY2 ##1 state == FRS_IDLE);
    COV_MSG: cover property (reconf_msg_valid);
    COV_REPLAY: cover property (retry_valid ##1 retry_valid);

endmodule

// File: logic/frs_defs.svh
// Constants for the fault recovery sequencer
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH
`define FRS_CLK_NS 4
`define FRS_US_NS 1000
`define FRS_WAIT_MIN_US 21'd20
`define FRS_WAIT_MAX_US 21'd2000000
`define FRS_RETRY_WATCH 4'h3
`define FRS_TAGS 8
`define FRS_TAG_W 3
`endif

// File: logic/frs_pkg.sv
// Types for the fault recovery sequencer
package frs_pkg;
    typedef struct packed {
        logic [3:0] err_type;
        logic [7:0] err_loc;
    } frs_rpt_t;
    typedef enum logic [2:0] {
        FRS_IDLE = 3'b000,
        FRS_WAIT1 = 3'b001,
        FRS_RETRY1 = 3'b010,
        FRS_WAIT2 = 3'b011,
        FRS_RETRY2 = 3'b100
    } frs_state_t;
endpackage

// File: verif/frs_proc_model.sv
// Model of the processors attached to a bus interface node
`timescale 1ns/100ps

module frs_proc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Reconfiguration message
    input wire logic reconf_msg_valid,
    input wire logic [3:0] reconf_msg_dest,
    // Pending interrupt or dispatch per processor
    output logic [3:0] irq_pend
);
    import frs_pkg::*;
    // ------------------------------------------
    // Each addressed processor takes the message
    // ------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend <= 4'h0;
        end else if (reconf_msg_valid) begin
            irq_pend <= irq_pend | reconf_msg_dest;
        end
    end
endmodule

// File: verif/fault_recovery_sequencer_tb_top.sv
// Self-checking bench for the fault recovery sequencer
`timescale 1ns/100ps
`include "frs_defs.svh"
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("mismatch at %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
end

module fault_recovery_sequencer_tb_top;
    import frs_pkg::*;
    // ------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic init = 1'b0;
    logic [7:0] node_addr_in = 8'h5a;
    logic [20:0] wait_time_us = 21'h000014;
    logic [3:0] attached_procs = 4'hb;
    logic node_is_bus_interface = 1'b1;
    logic err_valid = 1'b0;
    logic det_valid = 1'b0;
    logic acc_start = 1'b0;
    logic acc_done = 1'b0;
    frs_rpt_t err_rpt = '0;
    frs_rpt_t det_rpt = '0;
    logic [2:0] acc_start_tag = 3'h0;
    logic [2:0] acc_done_tag = 3'h0;
    logic [7:0] node_addr;
    logic bcast_valid, quiescent, retry_valid, isolate_valid, spare_enable, reconf_msg_valid;
    logic log_valid, perm_flag;
    frs_rpt_t bcast_rpt, isolate_rpt, log_rpt, bcast_cap, iso_cap;
    logic [2:0] retry_tag;
    logic [3:0] reconf_msg_dest, msg_cap, irq_pend;
    logic [2:0] retry_q[$];
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int q_cnt = 0;
    int wait_len = 0;
    int n_bcast = 0;
    int n_iso = 0;
    int n_msg = 0;

    always #2 clk = ~clk;

    frs_sequencer dut (.clk(clk), .rst_n(rst_n), .init(init), .node_addr_in(node_addr_in),
        .node_addr(node_addr), .wait_time_us(wait_time_us), .node_is_bus_interface(node_is_bus_interface),
        .attached_procs(attached_procs), .err_valid(err_valid), .err_rpt(err_rpt),
        .det_valid(det_valid), .det_rpt(det_rpt), .bcast_valid(bcast_valid), .bcast_rpt(bcast_rpt),
        .acc_start(acc_start), .acc_start_tag(acc_start_tag), .acc_done(acc_done),
        .acc_done_tag(acc_done_tag), .quiescent(quiescent), .retry_valid(retry_valid),
        .retry_tag(retry_tag), .isolate_valid(isolate_valid), .isolate_rpt(isolate_rpt),
        .spare_enable(spare_enable), .reconf_msg_valid(reconf_msg_valid), .reconf_msg_dest(reconf_msg_dest),
        .log_valid(log_valid), .log_rpt(log_rpt), .perm_flag(perm_flag));

    frs_proc_model proc (.clk(clk), .rst_n(rst_n), .reconf_msg_valid(reconf_msg_valid),
        .reconf_msg_dest(reconf_msg_dest), .irq_pend(irq_pend));

    // ------------------------------------------
    // Pulse capture and timeout
    // ------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (quiescent === 1'b1) q_cnt++;
        if (retry_valid === 1'b1) begin
            if (retry_q.size() == 0) wait_len = q_cnt;
            retry_q.push_back(retry_tag);
        end
        if (bcast_valid === 1'b1) begin n_bcast++; bcast_cap = bcast_rpt; end
        if (isolate_valid === 1'b1) begin n_iso++; iso_cap = isolate_rpt; end
        if (reconf_msg_valid === 1'b1) begin n_msg++; msg_cap = reconf_msg_dest; end
        if (cyc == 40000) begin n_fail++; test_done(); end
    end

    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pulse_err(input frs_rpt_t r);
        err_rpt = r;
        err_valid = 1'b1;
        step(1);
        err_valid = 1'b0;
        step(1);
    endtask

    task automatic acc(input logic done, input logic [2:0] tag);
        acc_start = !done;
        acc_done = done;
        acc_start_tag = tag;
        acc_done_tag = tag;
        step(1);
        acc_start = 1'b0;
        acc_done = 1'b0;
        step(1);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (quiescent !== 1'b0 && k < 12000) begin step(1); k++; end
    endtask

    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic test_init();
        init = 1'b1;
        step(1);
        init = 1'b0;
        step(1);
        `CHK(node_addr, 8'h5a)
        `CHK(quiescent, 1'b0)
        `CHK(log_valid, 1'b0)
        $display("test_init done");
    endtask

    task automatic test_detect();
        det_rpt = '{err_type: 4'h3, err_loc: 8'h21};
        det_valid = 1'b1;
        step(1);
        det_valid = 1'b0;
        step(2);
        `CHK(n_bcast, 1)
        `CHK(bcast_cap, 12'h321)
        $display("test_detect done");
    endtask

    task automatic test_transient();
        wait_time_us = 21'h000005;
        acc(1'b0, 3'h2);
        acc(1'b0, 3'h5);
        acc(1'b0, 3'h1);
        acc(1'b1, 3'h1);
        q_cnt = 0;
        err_rpt = 12'h110;
        err_valid = 1'b1;
        step(1);
        err_rpt = 12'h244;
        step(1);
        err_valid = 1'b0;
        step(1);
        `CHK(quiescent, 1'b1)
        `CHK(log_valid, 1'b1)
        `CHK(log_rpt, 12'h244)
        wait_idle();
        `CHK(quiescent, 1'b0)
        `CHK(retry_q.size(), 2)
        `CHK(retry_q[0], 3'h2)
        `CHK(retry_q[1], 3'h5)
        `CHK(wait_len >= 4998 && wait_len <= 5008, 1'b1)
        `CHK(perm_flag, 1'b0)
        `CHK(n_msg, 0)
        `CHK(log_rpt, 12'h244)
        `CHK(n_iso, 0)
        `CHK(spare_enable, 1'b0)
        $display("test_transient done");
    endtask

    task automatic test_perm();
        int k;
        wait_time_us = 21'h000014;
        retry_q.delete();
        pulse_err(12'h681);
        k = 0;
        while (retry_q.size() == 0 && k < 6000) begin step(1); k++; end
        pulse_err(12'h681);
        step(1);
        `CHK(n_iso, 1)
        `CHK(iso_cap, 12'h681)
        `CHK(spare_enable, 1'b1)
        `CHK(perm_flag, 1'b1)
        `CHK(quiescent, 1'b1)
        `CHK(n_msg, 0)
        retry_q.delete();
        wait_idle();
        `CHK(quiescent, 1'b0)
        step(1);
        `CHK(retry_q.size(), 2)
        `CHK(retry_q[1], 3'h5)
        `CHK(n_msg, 1)
        `CHK(msg_cap, 4'hb)
        `CHK(irq_pend, 4'hb)
        $display("test_perm done");
    endtask

    task automatic test_no_msg();
        int k;
        node_is_bus_interface = 1'b0;
        n_msg = 0;
        pulse_err(12'h7c2);
        k = 0;
        while (retry_valid !== 1'b1 && k < 6000) begin step(1); k++; end
        pulse_err(12'h7c3);
        step(10);
        `CHK(quiescent, 1'b1)
        `CHK(perm_flag, 1'b0)
        k = 0;
        while (retry_valid !== 1'b1 && k < 6000) begin step(1); k++; end
        pulse_err(12'h7c3);
        `CHK(perm_flag, 1'b1)
        `CHK(iso_cap, 12'h7c3)
        wait_idle();
        step(1);
        `CHK(quiescent, 1'b0)
        `CHK(n_msg, 0)
        `CHK(irq_pend, 4'hb)
        node_is_bus_interface = 1'b1;
        $display("test_no_msg done");
    endtask

    task automatic test_init_mid();
        pulse_err(12'h155);
        `CHK(quiescent, 1'b1)
        init = 1'b1;
        step(1);
        init = 1'b0;
        step(1);
        `CHK(quiescent, 1'b0)
        `CHK(spare_enable, 1'b0)
        `CHK(perm_flag, 1'b0)
        `CHK(log_valid, 1'b0)
        $display("test_init_mid done");
    endtask

    initial begin
        step(6);
        rst_n = 1'b1;
        step(1);
        test_init();
        test_detect();
        test_transient();
        test_perm();
        test_no_msg();
        test_init_mid();
        test_done();
    end
endmodule
